// file: include/mag_defs.svh
// Constants for the address generation block: widths, offsets, bit positions, reset values
`ifndef MAG_DEFS_SVH
`define MAG_DEFS_SVH

`define MAG_PC_W        14
`define MAG_RAM_W       10
`define MAG_PAGE_BITS   8
`define MAG_ZP_BITS     6
`define MAG_MREG_BASE   10'h020
`define MAG_MREG_HI     6'h02
`define MAG_ROM_ACC_BIT 8
`define MAG_ROM_PORT_BIT 9
`define MAG_PC_RESET    14'h0000

`endif

// file: include/mag_pkg.sv
// Types shared by the address generation block
package mag_pkg;

    // Operation requested by the instruction decoder
    typedef enum logic [3:0] {
        MAG_OP_NONE      = 4'h0,
        MAG_OP_RAM_IND   = 4'h1,
        MAG_OP_RAM_DIR   = 4'h2,
        MAG_OP_MREG_LOAD = 4'h3,
        MAG_OP_MREG_SWAP = 4'h4,
        MAG_OP_JMP_LONG  = 4'h5,
        MAG_OP_JMP_COND  = 4'h6,
        MAG_OP_CALL_LONG = 4'h7,
        MAG_OP_JMP_LOCAL = 4'h8,
        MAG_OP_CALL_ZERO = 4'h9,
        MAG_OP_TBL_JUMP  = 4'ha,
        MAG_OP_TBL_READ  = 4'hb
    } mag_op_t;

    // Sequencer state, Gray coded along idle -> fetch -> idle
    typedef enum logic [1:0] {
        MAG_ST_IDLE  = 2'b00,
        MAG_ST_FETCH = 2'b01
    } mag_state_t;

endpackage

// file: rtl/mag_addr_calc.sv
// Combinational RAM address and program counter target calculation
`timescale 1ns/1ps
`include "mag_defs.svh"

module mag_addr_calc
    import mag_pkg::*;
(
    input  wire mag_op_t                  op_in,
    input  wire logic [`MAG_PC_W-1:0]     pc_inc_in,
    input  wire logic [13:0]              imm_in,
    input  wire logic [1:0]               w_in,
    input  wire logic [3:0]               x_in,
    input  wire logic [3:0]               y_in,
    input  wire logic [3:0]               acc_in,
    input  wire logic [3:0]               aux_in,
    input  wire logic                     status_in,
    output logic      [`MAG_RAM_W-1:0]    ram_addr_out,
    output logic                          ram_hit_out,
    output logic      [`MAG_PC_W-1:0]     pc_target_out,
    output logic      [`MAG_PC_W-1:0]     tbl_addr_out
);

    always_comb begin
        // Immediate high, accumulator middle, aux low; top bits cleared
        tbl_addr_out = {2'h0, imm_in[3:0], acc_in, aux_in};
        ram_addr_out = '0;
        ram_hit_out  = 1'b0;
        unique case (op_in)
            MAG_OP_RAM_IND: begin
                ram_addr_out = {w_in, x_in, y_in};
                ram_hit_out  = 1'b1;
            end
            MAG_OP_RAM_DIR: begin
                ram_addr_out = imm_in[`MAG_RAM_W-1:0];
                ram_hit_out  = 1'b1;
            end
            MAG_OP_MREG_LOAD, MAG_OP_MREG_SWAP: begin
                ram_addr_out = `MAG_MREG_BASE | {6'h00, imm_in[3:0]};
                ram_hit_out  = 1'b1;
            end
            default: begin
                ram_addr_out = '0;
                ram_hit_out  = 1'b0;
            end
        endcase
    end

    always_comb begin
        pc_target_out = pc_inc_in;
        unique case (op_in)
            MAG_OP_JMP_LONG, MAG_OP_CALL_LONG: begin
                pc_target_out = imm_in;
            end
            MAG_OP_JMP_COND: begin
                if (status_in) begin
                    pc_target_out = imm_in;
                end
            end
            MAG_OP_JMP_LOCAL: begin
                // Page part comes from the already advanced counter, so the
                // last word of a page branches into the next page
                if (status_in) begin
                    pc_target_out = {pc_inc_in[`MAG_PC_W-1:`MAG_PAGE_BITS],
                                     imm_in[`MAG_PAGE_BITS-1:0]};
                end
            end
            MAG_OP_CALL_ZERO: begin
                if (status_in) begin
                    pc_target_out = {8'h00, imm_in[`MAG_ZP_BITS-1:0]};
                end
            end
            MAG_OP_TBL_JUMP: begin
                pc_target_out = tbl_addr_out;
            end
            default: begin
                pc_target_out = pc_inc_in;
            end
        endcase
    end

endmodule

// file: rtl/mag_core.sv
// Address generation for the 4-bit core: program counter, RAM address, table reads
`timescale 1ns/1ps
`include "mag_defs.svh"

// Function
// - Register indirect RAM address joins the top, middle and low address fields into 10 bits.
// - Direct RAM access uses the whole 10-bit second instruction word as the address.
// - A 16-digit memory register region is reached by load and swap with a 4-bit digit select.
// - Long jump, taken long conditional jump and long call load all 14 counter bits.
// - Program memory is split into 256-word pages starting at address zero.
// - A taken local jump replaces only the low 8 bits of the advanced counter and keeps its page.
// - A local jump at page offset 255 lands in the next page since the page was advanced.
// - A taken zero page call puts 6 immediate bits in the counter low bits and clears the rest.
// - Table jump goes to the address built from immediate, accumulator and aux nibbles.
// - Table read with ROM bit 8 set writes the low 8 bits to accumulator and aux.
// - Table read with ROM bit 9 set writes the low 8 bits to the two port registers.
// - Table read with bits 8 and 9 set performs both writes in the same instruction.
// - Table read only advances the counter; the table address serves the data fetch.

module mag_core
    import mag_pkg::*;
(
    input  wire logic                  clk_sys_in,
    input  wire logic                  reset_in,
    input  wire logic                  op_valid_in,
    input  wire mag_op_t               op_code_in,
    input  wire logic [13:0]           imm_in,
    input  wire logic [1:0]            w_in,
    input  wire logic [3:0]            x_in,
    input  wire logic [3:0]            y_in,
    input  wire logic [3:0]            acc_in,
    input  wire logic [3:0]            aux_in,
    input  wire logic                  status_in,
    input  wire logic [9:0]            rom_data_in,
    output logic                       ready_out,
    output logic [`MAG_PC_W-1:0]       pc_out,
    output logic [`MAG_RAM_W-1:0]      ram_addr_out,
    output logic                       ram_valid_out,
    output logic                       ram_swap_out,
    output logic [`MAG_PC_W-1:0]       tbl_addr_out,
    output logic                       tbl_rd_out,
    output logic [3:0]                 acc_out,
    output logic [3:0]                 aux_out,
    output logic                       acc_we_out,
    output logic [3:0]                 port_out_one_out,
    output logic [3:0]                 port_out_two_out,
    output logic                       port_we_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mag_state_t              state_r,     state_nxt;
    logic                    ready_r,     ready_nxt;
    logic [`MAG_PC_W-1:0]    pc_r,        pc_nxt;
    logic [`MAG_RAM_W-1:0]   ram_addr_r,  ram_addr_nxt;
    logic                    ram_valid_r, ram_valid_nxt;
    logic                    ram_swap_r,  ram_swap_nxt;
    logic [`MAG_PC_W-1:0]    tbl_addr_r,  tbl_addr_nxt;
    logic                    tbl_rd_r,    tbl_rd_nxt;
    logic [3:0]              acc_r,       acc_nxt;
    logic [3:0]              aux_r,       aux_nxt;
    logic                    acc_we_r,    acc_we_nxt;
    logic [3:0]              port_one_r,  port_one_nxt;
    logic [3:0]              port_two_r,  port_two_nxt;
    logic                    port_we_r,   port_we_nxt;

    logic                    accept;
    logic [`MAG_PC_W-1:0]    pc_inc;
    logic [`MAG_RAM_W-1:0]   calc_ram_addr;
    logic                    calc_ram_hit;
    logic [`MAG_PC_W-1:0]    calc_pc;
    logic [`MAG_PC_W-1:0]    calc_tbl;

    // Requests arriving while a table fetch is pending are ignored
    assign accept = op_valid_in && ready_r;
    assign pc_inc = pc_r + 14'h0001;

    mag_addr_calc u_calc (
        .op_in         (op_code_in),
        .pc_inc_in     (pc_inc),
        .imm_in        (imm_in),
        .w_in          (w_in),
        .x_in          (x_in),
        .y_in          (y_in),
        .acc_in        (acc_in),
        .aux_in        (aux_in),
        .status_in     (status_in),
        .ram_addr_out  (calc_ram_addr),
        .ram_hit_out   (calc_ram_hit),
        .pc_target_out (calc_pc),
        .tbl_addr_out  (calc_tbl)
    );

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        ready_nxt     = ready_r;
        pc_nxt        = pc_r;
        ram_addr_nxt  = ram_addr_r;
        ram_valid_nxt = 1'b0;
        ram_swap_nxt  = 1'b0;
        tbl_addr_nxt  = tbl_addr_r;
        tbl_rd_nxt    = 1'b0;
        acc_nxt       = acc_r;
        aux_nxt       = aux_r;
        acc_we_nxt    = 1'b0;
        port_one_nxt  = port_one_r;
        port_two_nxt  = port_two_r;
        port_we_nxt   = 1'b0;
        unique case (state_r)
            MAG_ST_IDLE: begin
                if (accept) begin
                    pc_nxt        = calc_pc;
                    ram_valid_nxt = calc_ram_hit;
                    ram_swap_nxt  = (op_code_in == MAG_OP_MREG_SWAP);
                    if (calc_ram_hit) begin
                        ram_addr_nxt = calc_ram_addr;
                    end
                    if (op_code_in == MAG_OP_TBL_READ) begin
                        // Counter only advances; table address goes to the ROM port
                        tbl_addr_nxt = calc_tbl;
                        tbl_rd_nxt   = 1'b1;
                        state_nxt    = MAG_ST_FETCH;
                        ready_nxt    = 1'b0;
                    end
                end
            end
            MAG_ST_FETCH: begin
                // Both writes may happen in the same cycle
                if (rom_data_in[`MAG_ROM_ACC_BIT]) begin
                    acc_nxt    = rom_data_in[7:4];
                    aux_nxt    = rom_data_in[3:0];
                    acc_we_nxt = 1'b1;
                end
                if (rom_data_in[`MAG_ROM_PORT_BIT]) begin
                    port_one_nxt = rom_data_in[7:4];
                    port_two_nxt = rom_data_in[3:0];
                    port_we_nxt  = 1'b1;
                end
                state_nxt = MAG_ST_IDLE;
                ready_nxt = 1'b1;
            end
            default: begin
                state_nxt = MAG_ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_r     <= MAG_ST_IDLE;
            ready_r     <= 1'b1;
            pc_r        <= `MAG_PC_RESET;
            ram_addr_r  <= '0;
            ram_valid_r <= 1'b0;
            ram_swap_r  <= 1'b0;
            tbl_addr_r  <= '0;
            tbl_rd_r    <= 1'b0;
            acc_r       <= 4'h0;
            aux_r       <= 4'h0;
            acc_we_r    <= 1'b0;
            port_one_r  <= 4'h0;
            port_two_r  <= 4'h0;
            port_we_r   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            ready_r     <= ready_nxt;
            pc_r        <= pc_nxt;
            ram_addr_r  <= ram_addr_nxt;
            ram_valid_r <= ram_valid_nxt;
            ram_swap_r  <= ram_swap_nxt;
            tbl_addr_r  <= tbl_addr_nxt;
            tbl_rd_r    <= tbl_rd_nxt;
            acc_r       <= acc_nxt;
            aux_r       <= aux_nxt;
            acc_we_r    <= acc_we_nxt;
            port_one_r  <= port_one_nxt;
            port_two_r  <= port_two_nxt;
            port_we_r   <= port_we_nxt;
        end
    end

    assign ready_out        = ready_r;
    assign pc_out           = pc_r;
    assign ram_addr_out     = ram_addr_r;
    assign ram_valid_out    = ram_valid_r;
    assign ram_swap_out     = ram_swap_r;
    assign tbl_addr_out     = tbl_addr_r;
    assign tbl_rd_out       = tbl_rd_r;
    assign acc_out          = acc_r;
    assign aux_out          = aux_r;
    assign acc_we_out       = acc_we_r;
    assign port_out_one_out = port_one_r;
    assign port_out_two_out = port_two_r;
    assign port_we_out      = port_we_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    a_ram_ind_addr: assert property (
        accept && op_code_in == MAG_OP_RAM_IND |=>
            ram_valid_out && ram_addr_out == {$past(w_in), $past(x_in), $past(y_in)})
        else $error("indirect RAM address wrong");

    a_ram_dir_addr: assert property (
        accept && op_code_in == MAG_OP_RAM_DIR |=>
            ram_valid_out && ram_addr_out == $past(imm_in[9:0]))
        else $error("direct RAM address wrong");

    a_mreg_region: assert property (
        accept && (op_code_in == MAG_OP_MREG_LOAD || op_code_in == MAG_OP_MREG_SWAP) |=>
            ram_addr_out[9:4] == `MAG_MREG_HI && ram_addr_out[3:0] == $past(imm_in[3:0]))
        else $error("memory register address wrong");

    a_long_jump_pc: assert property (
        accept && (op_code_in == MAG_OP_JMP_LONG || op_code_in == MAG_OP_CALL_LONG ||
                   (op_code_in == MAG_OP_JMP_COND && status_in)) |=>
            pc_out == $past(imm_in))
        else $error("long jump target wrong");

    a_local_jump_page: assert property (
        accept && op_code_in == MAG_OP_JMP_LOCAL && status_in && pc_out[7:0] != 8'hff |=>
            pc_out == {$past(pc_out[13:8]), $past(imm_in[7:0])})
        else $error("local jump left its page");

    a_local_jump_wrap: assert property (
        accept && op_code_in == MAG_OP_JMP_LOCAL && status_in && pc_out[7:0] == 8'hff |=>
            pc_out[13:8] == $past(pc_out[13:8]) + 6'h01)
        else $error("page boundary jump not in next page");

    a_zero_page_call: assert property (
        accept && op_code_in == MAG_OP_CALL_ZERO && status_in |=>
            pc_out == {8'h00, $past(imm_in[5:0])})
        else $error("zero page call target wrong");

    a_tbl_jump_target: assert property (
        accept && op_code_in == MAG_OP_TBL_JUMP |=>
            pc_out == {2'h0, $past(imm_in[3:0]), $past(acc_in), $past(aux_in)})
        else $error("table jump target wrong");

    a_tbl_read_pc: assert property (
        accept && op_code_in == MAG_OP_TBL_READ |=>
            pc_out == $past(pc_out) + 14'h0001 && tbl_rd_out ##1
            pc_out == $past(pc_out) && ready_out)
        else $error("table read disturbed the counter");

    a_tbl_acc_write: assert property (
        state_r == MAG_ST_FETCH && rom_data_in[8] |=>
            acc_we_out && {acc_out, aux_out} == $past(rom_data_in[7:0]))
        else $error("table read did not load accumulator pair");

    a_tbl_port_write: assert property (
        state_r == MAG_ST_FETCH && rom_data_in[9] |=>
            port_we_out && {port_out_one_out, port_out_two_out} == $past(rom_data_in[7:0]))
        else $error("table read did not load port registers");

    a_tbl_both_write: assert property (
        state_r == MAG_ST_FETCH && rom_data_in[9:8] == 2'b11 |=> acc_we_out && port_we_out)
        else $error("table read missed one of the two writes");

    c_page_wrap: cover property (
        accept && op_code_in == MAG_OP_JMP_LOCAL && status_in && pc_out[7:0] == 8'hff);
    c_tbl_both: cover property (state_r == MAG_ST_FETCH && rom_data_in[9:8] == 2'b11);
    c_mreg_swap: cover property (accept && op_code_in == MAG_OP_MREG_SWAP);
    c_tbl_jump: cover property (accept && op_code_in == MAG_OP_TBL_JUMP);

endmodule

// file: dv/mag_rom_model.sv
// Program ROM stand-in that answers the table fetches of the address generation block
`timescale 1ns/1ps

module mag_rom_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rd_in,
    input  wire logic [13:0] addr_in,
    output logic      [9:0]  data_out
);
    logic [9:0] junk_r = 10'h155;

    // Outside a fetch the word flips every cycle, so a late sample cannot pass by luck
    always_ff @(posedge clk_sys_in) begin
        junk_r <= ~junk_r;
    end

    // Low address bits pick the steering bits, so every aux value mix reaches both enables
    always_comb begin
        data_out = rd_in ? {addr_in[1:0], ~addr_in[7:0]} : junk_r;
    end
endmodule

// file: dv/mag_core_tb.sv
// Self-checking bench for the address generation block against a behavioural model
`timescale 1ns/1ps
`include "mag_defs.svh"

module mag_core_tb;
    import mag_pkg::*;
    logic        clk_sys_in  = 1'b0;
    logic        reset_in    = 1'b1;
    logic        op_valid_in = 1'b0;
    mag_op_t     op_code_in  = MAG_OP_NONE;
    logic [13:0] imm_in      = 14'h0000;
    logic [1:0]  w_in        = 2'h0;
    logic [3:0]  x_in        = 4'h0;
    logic [3:0]  y_in        = 4'h0;
    logic [3:0]  acc_in      = 4'h0;
    logic [3:0]  aux_in      = 4'h0;
    logic        status_in   = 1'b0;
    logic [9:0]  rom_data_in;
    logic        ready_out, ram_valid_out, ram_swap_out, tbl_rd_out, acc_we_out, port_we_out;
    logic [13:0] pc_out, tbl_addr_out;
    logic [9:0]  ram_addr_out;
    logic [3:0]  acc_out, aux_out, port_out_one_out, port_out_two_out;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h118685ce;
    logic [13:0] exp_pc = 14'h0000;
    logic [13:0] exp_tbl = 14'h0000;
    logic [9:0]  exp_ram = 10'h000;
    logic [3:0]  exp_acc = 4'h0, exp_aux = 4'h0, exp_p1 = 4'h0, exp_p2 = 4'h0;

    always #50 clk_sys_in = ~clk_sys_in;

    mag_core i_mag_core (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .imm_in(imm_in), .w_in(w_in), .x_in(x_in), .y_in(y_in),
        .acc_in(acc_in), .aux_in(aux_in), .status_in(status_in), .rom_data_in(rom_data_in),
        .ready_out(ready_out), .pc_out(pc_out), .ram_addr_out(ram_addr_out),
        .ram_valid_out(ram_valid_out), .ram_swap_out(ram_swap_out), .tbl_addr_out(tbl_addr_out),
        .tbl_rd_out(tbl_rd_out), .acc_out(acc_out), .aux_out(aux_out), .acc_we_out(acc_we_out),
        .port_out_one_out(port_out_one_out), .port_out_two_out(port_out_two_out),
        .port_we_out(port_we_out));

    mag_rom_model i_mag_rom_model (.clk_sys_in(clk_sys_in), .rd_in(tbl_rd_out),
        .addr_in(tbl_addr_out), .data_out(rom_data_in));

    // ------------------------------------------------------------
    // Comparison and reporting
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic report(input string n, input logic [13:0] e, input logic [13:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pc(input string n, input logic [13:0] e, input logic [13:0] g);
        report(n, e, g);
    endtask
    task automatic chk_addr(input string n, input logic [13:0] e, input logic [13:0] g);
        report(n, e, g);
    endtask
    task automatic chk_nib(input string n, input logic [3:0] e, input logic [3:0] g);
        report(n, {10'h000, e}, {10'h000, g});
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        report(n, {13'h0000, e}, {13'h0000, g});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One operation: drive at the falling edge, predict, check one cycle later
    // ------------------------------------------------------------
    task automatic run_op(input mag_op_t op, input logic [13:0] imm, input logic [3:0] a,
                          input logic [3:0] b, input logic st, input logic vld);
        logic [13:0] nx;
        logic [9:0]  wxy;
        logic [9:0]  rw;
        logic        tr;
        logic        rv;
        wxy = 10'(rnd());
        op_valid_in = vld;
        op_code_in = op;
        imm_in = imm;
        {w_in, x_in, y_in} = wxy;
        acc_in = a;
        aux_in = b;
        status_in = st;
        nx = exp_pc + 14'h0001;
        tr = vld && op == MAG_OP_TBL_READ;
        rv = vld && (op inside {[MAG_OP_RAM_IND:MAG_OP_MREG_SWAP]});
        if (vld) begin
            case (op)
                MAG_OP_RAM_IND: exp_ram = wxy;
                MAG_OP_RAM_DIR: exp_ram = imm[9:0];
                MAG_OP_MREG_LOAD, MAG_OP_MREG_SWAP: exp_ram = `MAG_MREG_BASE + imm[3:0];
                MAG_OP_JMP_LONG, MAG_OP_CALL_LONG: nx = imm;
                MAG_OP_JMP_COND: nx = st ? imm : nx;
                MAG_OP_JMP_LOCAL: nx = st ? {nx[13:8], imm[7:0]} : nx;
                MAG_OP_CALL_ZERO: nx = st ? {8'h00, imm[5:0]} : nx;
                MAG_OP_TBL_JUMP: nx = {2'b00, imm[3:0], a, b};
                MAG_OP_TBL_READ: exp_tbl = {2'b00, imm[3:0], a, b};
                default: ;
            endcase
            exp_pc = nx;
        end
        @(negedge clk_sys_in);
        chk_pc("pc", exp_pc, pc_out);
        chk_addr("ram_addr", {4'h0, exp_ram}, {4'h0, ram_addr_out});
        chk_bit("ram_valid", rv, ram_valid_out);
        chk_bit("ram_swap", vld && op == MAG_OP_MREG_SWAP, ram_swap_out);
        chk_bit("tbl_rd", tr, tbl_rd_out);
        chk_addr("tbl_addr", exp_tbl, tbl_addr_out);
        chk_bit("ready", !tr, ready_out);
        if (tr) begin
            // A request in the dead cycle must be dropped without a trace
            op_code_in = MAG_OP_JMP_LONG;
            imm_in = 14'(rnd());
            rw = {exp_tbl[1:0], ~exp_tbl[7:0]};
            exp_acc = rw[8] ? rw[7:4] : exp_acc;
            exp_aux = rw[8] ? rw[3:0] : exp_aux;
            exp_p1 = rw[9] ? rw[7:4] : exp_p1;
            exp_p2 = rw[9] ? rw[3:0] : exp_p2;
            @(negedge clk_sys_in);
            chk_bit("acc_we", rw[8], acc_we_out);
            chk_bit("port_we", rw[9], port_we_out);
            chk_pc("pc_dead", exp_pc, pc_out);
            chk_bit("ready_back", 1'b1, ready_out);
        end else begin
            chk_bit("acc_we_idle", 1'b0, acc_we_out);
            chk_bit("port_we_idle", 1'b0, port_we_out);
        end
        chk_nib("acc", exp_acc, acc_out);
        chk_nib("aux", exp_aux, aux_out);
        chk_nib("port_one", exp_p1, port_out_one_out);
        chk_nib("port_two", exp_p2, port_out_two_out);
    endtask

    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] r;
        repeat (10) @(negedge clk_sys_in);
        reset_in = 1'b0;
        @(negedge clk_sys_in);
        chk_pc("pc_reset", 14'h0000, pc_out);
        chk_bit("ready_reset", 1'b1, ready_out);
        // Local jumps from the last word of a page, taken and not taken
        run_op(MAG_OP_JMP_LONG, 14'h12ff, 4'h0, 4'h0, 1'b0, 1'b1);
        run_op(MAG_OP_JMP_LOCAL, 14'h0034, 4'h0, 4'h0, 1'b1, 1'b1);
        run_op(MAG_OP_JMP_LONG, 14'h00ff, 4'h0, 4'h0, 1'b0, 1'b1);
        run_op(MAG_OP_JMP_LOCAL, 14'h0034, 4'h0, 4'h0, 1'b0, 1'b1);
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            run_op(mag_op_t'(k % 12), r[13:0], r[17:14], r[21:18], k >= 12, 1'b1);
        end
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            run_op(MAG_OP_TBL_READ, r[13:0], r[17:14], 4'(k), 1'b1, 1'b1);
        end
        for (int i = 0; i < 600; i++) begin
            r = rnd();
            run_op(mag_op_t'(r[31:28] % 12), r[13:0], r[17:14], r[21:18], r[22], |r[24:23]);
        end
        op_valid_in = 1'b0;
        tally_and_finish();
    end
endmodule
